// ### src/ddpi_pkg.sv
/*
 * Constants shared by the display DRAM pin interface.
 * Assumes a single system clock; no software registers.
 */
package ddpi_pkg;
	// =========================================================
	// Bus widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int ROW_W  = 10;
	localparam int COL_W  = 10;

	// =========================================================
	// Cycle timing counts (clk_sys cycles at 25 MHz)
	localparam int CLK_NS       = 40;
	localparam int ADDR_SETUP_NS = 40;
	localparam int ADDR_SETUP_CYC =
		(ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_NS    = 80;
	localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 4;

	// =========================================================
	// Reset levels of strobes (all inactive high)
	localparam logic STROBE_IDLE = 1'b1;

	// =========================================================
	// Cycle sequencer states
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ROWA = 7'h02,
		ST_RAS  = 7'h04,
		ST_COLA = 7'h08,
		ST_CAS  = 7'h10,
		ST_DONE = 7'h20,
		ST_PRE  = 7'h40
	} ddpi_state_type;
endpackage : ddpi_pkg

// ### src/ddpi_top.sv
/*
 * Display DRAM pin interface: sequences one read or write cycle on
 * multiplexed address, strobes, output enable and 16-bit data bus.
 * Assumes requests held until acknowledged and strobe select static.
 */
// How it works
// (R1) Vertical sync goes to monitor with configurable active polarity.
// (R2) One active-low row strobe latches row address on ten-bit bus.
// (R3) Active-low column strobe latches column address on same bus.
// (R4) Select low: two byte write strobes, one shared column strobe.
// (R5) Select high: two byte column strobes, one shared write strobe.
// (R6) Address bits 0 and 9 carry row only for asymmetric parts.
// (R7) Sixteen-bit data bus: driven on writes, sampled on reads.
// (R8) Active-low output enable lets DRAMs drive read data.
// (R9) Strobe select is latched when idle, never changes mid-cycle.
// (R10) Address is valid one cycle before each strobe falls.
`timescale 1ns/1ps
`default_nettype none
module ddpi_top #(
	parameter int ADDR_SETUP = ddpi_pkg::ADDR_SETUP_CYC,
	parameter int STROBE_LEN = ddpi_pkg::STROBE_CYC
) (
	input  wire logic                       clk_sys,
	input  wire logic                       resetn,
	input  wire logic                       dram_strobe_select,
	input  wire logic                       asym_mode,
	input  wire logic                       req_valid,
	input  wire logic                       req_write,
	input  wire logic [1:0]                 req_byte_en,
	input  wire logic [ddpi_pkg::ROW_W-1:0] req_row,
	input  wire logic [ddpi_pkg::COL_W-1:0] req_col,
	input  wire logic [ddpi_pkg::DATA_W-1:0] req_wdata,
	output logic                            req_ack,
	output logic [ddpi_pkg::DATA_W-1:0]     rd_data,
	output logic                            rd_valid,
	input  wire logic                       vsync_active,
	input  wire logic                       vsync_pol_high,
	output logic                            vsync_pin,
	output logic [ddpi_pkg::ADDR_W-1:0]     memory_address_bus,
	output logic                            row_strobe_n,
	output logic                            pin127_n,
	output logic [1:0]                      pin_we_cas_n,
	output logic                            out_en_n,
	input  wire logic [ddpi_pkg::DATA_W-1:0] memory_data_bus_in,
	output logic [ddpi_pkg::DATA_W-1:0]     memory_data_bus_out,
	output logic                            memory_data_bus_oe
);
	import ddpi_pkg::*;

	typedef struct packed {
		ddpi_state_type        st;
		logic [CNT_W-1:0]      cnt;
		logic                  sel;
		logic                  wr;
		logic [1:0]            be;
		logic [COL_W-1:0]      col;
		logic [ADDR_W-1:0]     ma;
		logic                  ras_n;
		logic                  p127_n;
		logic [1:0]            p_n;
		logic                  oe_n;
		logic [DATA_W-1:0]     dout;
		logic                  doe;
		logic [DATA_W-1:0]     rdat;
		logic                  rval;
		logic                  ack;
	} ddpi_state_all_type;

	localparam logic [CNT_W-1:0] SETUP_M1 = CNT_W'(ADDR_SETUP - 1);
	localparam logic [CNT_W-1:0] STRB_M1  = CNT_W'(STROBE_LEN - 1);

	ddpi_state_all_type s_reg;
	ddpi_state_all_type s_next;

	// =========================================================
	// Memory cycle sequencer
	always_comb begin
		s_next = s_reg;
		s_next.ack  = 1'b0;
		s_next.rval = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
				s_next.sel = dram_strobe_select; // [R9]
				if (req_valid) begin
					s_next.wr  = req_write;
					s_next.be  = req_byte_en;
					s_next.col = req_col;
					s_next.ma  = req_row; // [R2]
					s_next.cnt = SETUP_M1;
					s_next.st  = ST_ROWA;
					if (req_write) begin
						s_next.dout = req_wdata; // [R7]
						s_next.doe  = 1'b1;
					end
				end
			end
			ST_ROWA: begin
				// Row address stands before row strobe falls
				if (s_reg.cnt == '0) begin
					s_next.ras_n = 1'b0; // [R2] [R10]
					s_next.cnt   = STRB_M1;
					s_next.st    = ST_RAS;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			ST_RAS: begin
				if (s_reg.cnt == '0) begin
					s_next.ma = s_reg.col; // [R3]
					if (asym_mode) begin
						s_next.ma[0] = 1'b0; // [R6]
						s_next.ma[ADDR_W-1] = 1'b0; // [R6]
					end
					s_next.oe_n = s_reg.wr; // [R8]
					s_next.cnt  = SETUP_M1;
					s_next.st   = ST_COLA;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			ST_COLA: begin
				if (s_reg.cnt == '0) begin
					if (s_reg.sel) begin
						// Byte column strobes, shared write strobe
						s_next.p_n    = ~s_reg.be; // [R5] [R10]
						s_next.p127_n = ~s_reg.wr; // [R5]
					end else begin
						// Byte write strobes, shared column strobe
						s_next.p127_n = 1'b0; // [R3] [R4] [R10]
						s_next.p_n    = s_reg.wr ? ~s_reg.be : 2'h3; // [R4]
					end
					s_next.cnt = STRB_M1;
					s_next.st  = ST_CAS;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			ST_CAS: begin
				if (s_reg.cnt == '0) begin
					s_next.st = ST_DONE;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			ST_DONE: begin
				// Sample read data at end of column strobe
				if (!s_reg.wr) begin
					s_next.rdat = memory_data_bus_in; // [R7]
					s_next.rval = 1'b1;
				end
				s_next.ras_n  = STROBE_IDLE;
				s_next.p127_n = STROBE_IDLE;
				s_next.p_n    = {2{STROBE_IDLE}};
				s_next.oe_n   = STROBE_IDLE;
				s_next.doe    = 1'b0;
				s_next.ack    = 1'b1;
				s_next.st     = ST_PRE;
			end
			ST_PRE: begin
				// One precharge cycle before next row
				s_next.st = ST_IDLE;
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_reg        <= '0;
			s_reg.st     <= ST_IDLE;
			s_reg.ras_n  <= STROBE_IDLE;
			s_reg.p127_n <= STROBE_IDLE;
			s_reg.p_n    <= {2{STROBE_IDLE}};
			s_reg.oe_n   <= STROBE_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops
	assign memory_address_bus  = s_reg.ma;
	assign row_strobe_n        = s_reg.ras_n;
	assign pin127_n            = s_reg.p127_n;
	assign pin_we_cas_n        = s_reg.p_n;
	assign out_en_n            = s_reg.oe_n;
	assign memory_data_bus_out = s_reg.dout;
	assign memory_data_bus_oe  = s_reg.doe;
	assign rd_data             = s_reg.rdat;
	assign rd_valid            = s_reg.rval;
	assign req_ack             = s_reg.ack;

	// Sync polarity stage
	ddpi_vsync_gen i_ddpi_vsync_gen (
		.clk_sys        (clk_sys),
		.resetn         (resetn),
		.vsync_active   (vsync_active),
		.vsync_pol_high (vsync_pol_high),
		.vsync_pin      (vsync_pin)
	);

	// =========================================================
	// Checks
	sequence ras_fall;
		$fell(row_strobe_n);
	endsequence

	a_row_addr_stable: assert property ( // [R2] [R10]
		@(posedge clk_sys) disable iff (!resetn)
		ras_fall |-> $stable(memory_address_bus))
		else $error("row address moved at row strobe");
	// Row strobe is released only as the end-of-cycle state is left
	a_single_row_strobe: assert property ( // [R2]
		@(posedge clk_sys) disable iff (!resetn)
		!row_strobe_n |->
		s_reg.st inside {ST_RAS, ST_COLA, ST_CAS, ST_DONE})
		else $error("row strobe outside cycle");
	a_col_after_row: assert property ( // [R3] [R10]
		@(posedge clk_sys) disable iff (!resetn)
		$fell(pin127_n) && !s_reg.sel |-> !row_strobe_n &&
		$stable(memory_address_bus))
		else $error("column strobe without row");
	a_dual_we_map: assert property ( // [R4]
		@(posedge clk_sys) disable iff (!resetn)
		!s_reg.sel && pin_we_cas_n != 2'h3 |-> s_reg.wr && !pin127_n)
		else $error("write strobe in dual write mode");
	a_dual_cas_map: assert property ( // [R5]
		@(posedge clk_sys) disable iff (!resetn)
		s_reg.sel && !pin127_n |-> s_reg.wr && pin_we_cas_n != 2'h3)
		else $error("shared write strobe misused");
	a_asym_col_bits: assert property ( // [R6]
		@(posedge clk_sys) disable iff (!resetn)
		s_reg.st == ST_CAS && asym_mode |->
		!memory_address_bus[0] && !memory_address_bus[ADDR_W-1])
		else $error("asym column bits used");
	a_data_drive: assert property ( // [R7] [R8]
		@(posedge clk_sys) disable iff (!resetn)
		memory_data_bus_oe |-> s_reg.wr && out_en_n)
		else $error("data bus contention");
	a_read_capture: assert property ( // [R7]
		@(posedge clk_sys) disable iff (!resetn)
		s_reg.st == ST_DONE && !s_reg.wr |=> rd_valid &&
		rd_data == $past(memory_data_bus_in))
		else $error("read data not captured");
	a_sel_static: assert property ( // [R9]
		@(posedge clk_sys) disable iff (!resetn)
		s_reg.st != ST_IDLE |=> $stable(s_reg.sel))
		else $error("strobe select changed mid cycle");
endmodule // ddpi_top
`default_nettype wire

// ### src/ddpi_vsync_gen.sv
/*
 * Vertical sync output stage with selectable polarity.
 * Assumes the raw sync request comes from the display timing logic.
 */
`timescale 1ns/1ps
`default_nettype none
module ddpi_vsync_gen (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic vsync_active,
	input  wire logic vsync_pol_high,
	output var  logic vsync_pin
);
	import ddpi_pkg::*;

	typedef struct packed {
		logic out;
	} ddpi_vs_type;

	ddpi_vs_type s_reg;
	ddpi_vs_type s_next;

	// =========================================================
	// Polarity select
	always_comb begin
		s_next = s_reg;
		s_next.out = vsync_pol_high ? vsync_active : ~vsync_active; // [R1]
	end

	// State register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign vsync_pin = s_reg.out;

	// First edge after reset still shows the reset level, so skip it
	a_vsync_polarity: assert property ( // [R1]
		@(posedge clk_sys) disable iff (!resetn)
		$past(resetn) |-> vsync_pin == ($past(vsync_pol_high)
			? $past(vsync_active) : ~$past(vsync_active)))
		else $error("vsync polarity wrong");
endmodule // ddpi_vsync_gen
`default_nettype wire

// ### verif/ddpi_dram_model.sv
/*
 * Behavioural model of the display DRAM array on the far side.
 * Assumes strobes are sampled on clk_sys; the board ties the strobe select.
 */
`timescale 1ns/1ps
`default_nettype none
module ddpi_dram_model (
	input  wire logic        clk_sys,
	input  wire logic        strobe_sel,
	input  wire logic [9:0]  addr,
	input  wire logic        row_n,
	input  wire logic        p127_n,
	input  wire logic [1:0]  wc_n,
	input  wire logic        oe_n,
	input  wire logic [15:0] ctl_dout,
	input  wire logic        ctl_oe,
	output logic [15:0]      bus
);
	logic [15:0] mem [int];
	logic [9:0]  row;
	logic [1:0]  cas_n;
	logic [1:0]  we_n;
	logic [15:0] last;
	logic [15:0] rd_q;
	logic [15:0] tmp;
	logic        prev_row;
	logic        prev_col;
	initial begin
		last = 16'h0000;
		rd_q = 16'h0000;
		row = 10'h000;
		prev_row = 1'b1;
		prev_col = 1'b0;
	end
	// =========================================================
	// Pin roles follow the strobe select
	assign cas_n = strobe_sel ? wc_n : {2{p127_n}};
	assign we_n  = strobe_sel ? {2{p127_n}} : wc_n;
	// Released bus shows a changing pattern, never the old value
	assign bus = ctl_oe ? ctl_dout :
		(!oe_n && cas_n != 2'b11) ? rd_q : ~last;
	// Row capture, column capture, byte writes
	always @(posedge clk_sys) begin
		last <= bus;
		prev_row <= row_n;
		prev_col <= (cas_n != 2'b11);
		if (prev_row && !row_n) begin
			row <= addr;
		end
		if (!prev_col && cas_n != 2'b11) begin
			tmp = mem.exists({row, addr}) ? mem[{row, addr}] : 16'h0000;
			for (int b = 0; b < 2; b++) begin
				if (!cas_n[b] && !we_n[b]) begin
					tmp[8*b +: 8] = bus[8*b +: 8];
				end
			end
			mem[{row, addr}] = tmp;
			rd_q <= tmp;
		end
	end
endmodule // ddpi_dram_model
`default_nettype wire

// ### verif/ddpi_top_tb.sv
/*
 * Self-checking bench for the display DRAM pin interface.
 * Assumes the DRAM model in ddpi_dram_model.sv and default timing.
 */
`timescale 1ns/1ps
`default_nettype none
module ddpi_top_tb;
	import ddpi_pkg::*;
	logic        clk_sys, resetn, sel, asym, req_valid, req_write;
	logic        vs_act, vs_pol, req_ack, rd_valid, vsync_pin;
	logic        row_strobe_n, pin127_n, out_en_n, memory_data_bus_oe;
	logic [1:0]  req_byte_en, pin_we_cas_n;
	logic [9:0]  req_row, req_col, memory_address_bus;
	logic [15:0] req_wdata, rd_data, memory_data_bus_in;
	logic [15:0] memory_data_bus_out;
	int          errors, total_checks;
	ddpi_top i_ddpi_top (.clk_sys(clk_sys), .resetn(resetn),
		.dram_strobe_select(sel), .asym_mode(asym), .req_valid(req_valid),
		.req_write(req_write), .req_byte_en(req_byte_en), .req_row(req_row),
		.req_col(req_col), .req_wdata(req_wdata), .req_ack(req_ack),
		.rd_data(rd_data), .rd_valid(rd_valid), .vsync_active(vs_act),
		.vsync_pol_high(vs_pol), .vsync_pin(vsync_pin),
		.memory_address_bus(memory_address_bus), .row_strobe_n(row_strobe_n),
		.pin127_n(pin127_n), .pin_we_cas_n(pin_we_cas_n), .out_en_n(out_en_n),
		.memory_data_bus_in(memory_data_bus_in),
		.memory_data_bus_out(memory_data_bus_out),
		.memory_data_bus_oe(memory_data_bus_oe));
	ddpi_dram_model i_ddpi_dram_model (.clk_sys(clk_sys), .strobe_sel(sel),
		.addr(memory_address_bus), .row_n(row_strobe_n), .p127_n(pin127_n),
		.wc_n(pin_we_cas_n), .oe_n(out_en_n), .ctl_dout(memory_data_bus_out),
		.ctl_oe(memory_data_bus_oe), .bus(memory_data_bus_in));
	// =========================================================
	// Clock, compare and verdict
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One memory cycle, watching the pins as it runs
	task automatic access(input logic w, input logic [1:0] be,
		input logic [9:0] r, input logic [9:0] c, input logic [15:0] d,
		input logic [15:0] e);
		int   n;
		logic pr, pc, cs;
		logic [9:0] cx;
		req_valid = 1'b1;
		req_write = w;
		req_byte_en = be;
		req_row = r;
		req_col = c;
		req_wdata = d;
		pr = 1'b1;
		pc = 1'b0;
		// Asymmetric parts carry no column bits 0 and 9
		cx = asym ? c & 10'h1FE : c;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			cs = sel ? (pin_we_cas_n != 2'b11) : !pin127_n;
			if (pr && !row_strobe_n)
				chk({6'h00, memory_address_bus}, {6'h00, r});
			if (!pc && cs)
				chk({6'h00, memory_address_bus}, {6'h00, cx});
			if (!out_en_n) chk({15'h0000, w}, 16'h0000);
			if (memory_data_bus_oe) chk(memory_data_bus_out, d);
			if (!sel && cs)
				chk({14'h0000, pin_we_cas_n}, {14'h0000, w ? ~be : 2'b11});
			if (sel && cs)
				chk({13'h0000, pin127_n, pin_we_cas_n}, {13'h0000, ~w, ~be});
			pr = row_strobe_n;
			pc = cs;
		end while (!req_ack && n < 20);
		req_valid = 1'b0;
		chk(16'(n), 16'h0008);
		chk({15'h0000, rd_valid}, {15'h0000, ~w});
		if (!w) chk(rd_data, e);
		repeat (3) @(negedge clk_sys);
	endtask
	// =========================================================
	// Scenarios
	task automatic t_idle;
		chk({11'h000, row_strobe_n, pin127_n, pin_we_cas_n, out_en_n},
			16'h001F);
		chk({15'h0000, memory_data_bus_oe}, 16'h0000);
	endtask
	task automatic t_vsync;
		for (int k = 0; k < 4; k++) begin
			vs_pol = k[1];
			vs_act = k[0];
			repeat (2) @(negedge clk_sys);
			chk({15'h0000, vsync_pin}, {15'h0000, k[1] ? k[0] : ~k[0]});
		end
	endtask
	task automatic t_dual_we;
		sel = 1'b0;
		access(1'b1, 2'b11, 10'h155, 10'h2AA, 16'hA5C3, 16'h0000);
		access(1'b1, 2'b10, 10'h155, 10'h2AA, 16'h7E00, 16'h0000);
		access(1'b0, 2'b11, 10'h155, 10'h2AA, 16'h0000, 16'h7EC3);
	endtask
	task automatic t_dual_cas;
		sel = 1'b1;
		access(1'b1, 2'b11, 10'h2AA, 10'h155, 16'h5A3C, 16'h0000);
		access(1'b1, 2'b01, 10'h2AA, 10'h155, 16'hFF81, 16'h0000);
		access(1'b0, 2'b11, 10'h2AA, 10'h155, 16'h0000, 16'h5A81);
	endtask
	task automatic t_asym;
		sel = 1'b0;
		asym = 1'b1;
		access(1'b1, 2'b11, 10'h3FF, 10'h3FF, 16'h1357, 16'h0000);
		asym = 1'b0;
		access(1'b0, 2'b11, 10'h3FF, 10'h1FE, 16'h0000, 16'h1357);
	endtask
	// Select pin wiggles during the row phase; roles must not follow
	task automatic t_sel_static;
		sel = 1'b0;
		fork
			access(1'b0, 2'b11, 10'h155, 10'h2AA, 16'h0000, 16'h7EC3);
			begin
				@(negedge clk_sys);
				sel = 1'b1;
				@(negedge clk_sys);
				sel = 1'b0;
			end
		join
	endtask
	// =========================================================
	// Main sequence and watchdog
	initial begin
		{resetn, sel, asym, req_valid, req_write, vs_act, vs_pol} = 7'h00;
		req_byte_en = 2'b00;
		req_row = 10'h000;
		req_col = 10'h000;
		req_wdata = 16'h0000;
		errors = 0;
		total_checks = 0;
		repeat (2) @(negedge clk_sys);
		t_idle();
		resetn = 1'b1;
		@(negedge clk_sys);
		t_idle();
		t_vsync();
		t_dual_we();
		t_dual_cas();
		t_asym();
		t_sel_static();
		summarize();
	end
	initial begin
		#80000;
		errors++;
		summarize();
	end
endmodule // ddpi_top_tb
`default_nettype wire
